// file: logic/bsfl_flag_bank.sv
/*
 * Status flag word and table stream descriptor of a bias controller.
 * Assumes a serial port decoder on core_clk delivering one-cycle strobes,
 * and alarm, queue and arithmetic status from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bsfl_regs.svh"
module bsfl_flag_bank (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register access strobes from the serial port.
    input  wire logic        flag_rd,
    input  wire logic        desc_wr,
    input  wire logic [15:0] desc_wdata,
    input  wire logic        sclr_wr,
    input  wire logic [15:0] sclr_wdata,
    input  wire logic        queue_rd,
    // Status from the rest of the device.
    input  wire logic        alu_busy,
    input  wire logic        stream_mode,
    input  wire logic        ch2_use_die_sensor,
    input  wire logic        queue_count_zero,
    input  wire logic        queue_full,
    input  wire logic        queue_push,
    input  wire logic        queue_pop,
    input  wire logic        queue_overflow,
    input  wire logic [3:0]  alarm_upper_i,
    input  wire logic [3:0]  alarm_lower_i,
    input  wire logic        die_upper_alarm,
    input  wire logic        die_lower_alarm,
    input  wire logic [15:0] queue_word,
    // Read data.
    output logic [15:0]      flag_rdata,
    output logic [15:0]      desc_rdata,
    output logic [15:0]      queue_rdata,
    // Descriptor fields and reset request.
    output logic [7:0]       stream_word_count,
    output logic [7:0]       stream_start_addr,
    output logic [8:0]       stream_words_total,
    output logic             full_reset_pulse
);
    logic [15:0]        flags_now;
    logic [15:0]        desc_reg;
    logic               restart_reg;
    logic               empty_reg;
    logic               stream_full_reg;
    logic               over_flag;
    logic [7:0]         alarm_flags;
    logic [7:0]         alarm_set;
    bsfl_pkg::bsfl_rst_t rst_state_reg;
    logic               full_reset_reg;

    // Channel 2 current bits take the die sensor alarms when selected.
    always_comb begin
        alarm_set[7] = ch2_use_die_sensor ? die_upper_alarm : alarm_upper_i[1];
        alarm_set[6] = ch2_use_die_sensor ? die_lower_alarm : alarm_lower_i[1];
        alarm_set[5] = ch2_use_die_sensor ? 1'b0 : alarm_upper_i[3];
        alarm_set[4] = ch2_use_die_sensor ? 1'b0 : alarm_lower_i[3];
        alarm_set[3] = alarm_upper_i[0];
        alarm_set[2] = alarm_lower_i[0];
        alarm_set[1] = alarm_upper_i[2];
        alarm_set[0] = alarm_lower_i[2];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_alarm
            bsfl_sticky_bit u_bit (
                .core_clk (core_clk),
                .reset    (reset),
                .set_evt  (alarm_set[gi]),
                .clr_evt  (flag_rd),
                .flag     (alarm_flags[gi])
            );
        end
    endgenerate

    // Overflow is sticky only in monitoring mode.
    bsfl_sticky_bit u_over (
        .core_clk (core_clk),
        .reset    (reset),
        .set_evt  (queue_overflow & ~stream_mode),
        .clr_evt  (flag_rd | stream_mode),
        .flag     (over_flag)
    );

    // Full flag in streaming mode drops on a pop.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stream_full_reg <= 1'b0;
        end else if (queue_pop) begin
            stream_full_reg <= 1'b0;
        end else begin
            stream_full_reg <= queue_full;
        end
    end

    // Empty flag drops as soon as a word is pushed.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            empty_reg <= 1'b1;
        end else if (queue_push) begin
            empty_reg <= 1'b0;
        end else begin
            empty_reg <= queue_count_zero;
        end
    end

    // Arm then execute in a later write triggers a full reset.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rst_state_reg  <= bsfl_pkg::BSFL_RST_IDLE;
            full_reset_reg <= 1'b0;
        end else begin
            full_reset_reg <= 1'b0;
            if (sclr_wr) begin
                case (rst_state_reg)
                    bsfl_pkg::BSFL_RST_IDLE: begin
                        if (sclr_wdata[`BSFL_SCLR_BIT_ARM] &
                            ~sclr_wdata[`BSFL_SCLR_BIT_EXECUTE]) begin
                            rst_state_reg <= bsfl_pkg::BSFL_RST_ARMED;
                        end
                    end
                    bsfl_pkg::BSFL_RST_ARMED: begin
                        if (sclr_wdata[`BSFL_SCLR_BIT_EXECUTE]) begin
                            full_reset_reg <= 1'b1;
                            rst_state_reg  <= bsfl_pkg::BSFL_RST_IDLE;
                        end else if (~sclr_wdata[`BSFL_SCLR_BIT_ARM]) begin
                            rst_state_reg <= bsfl_pkg::BSFL_RST_IDLE;
                        end
                    end
                    default: begin
                        rst_state_reg <= bsfl_pkg::BSFL_RST_IDLE;
                    end
                endcase
            end
        end
    end
    assign full_reset_pulse = full_reset_reg;

    // Restart flag: zero at power-up, set by full reset, cleared by read.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            restart_reg <= 1'b0;
        end else if (full_reset_reg) begin
            restart_reg <= 1'b1;
        end else if (flag_rd) begin
            restart_reg <= 1'b0;
        end
    end

    // Current flag word, reserved bits driven as zero.
    always_comb begin
        flags_now = 16'h0000;
        flags_now[`BSFL_BIT_ALU_BUSY] = alu_busy;
        flags_now[`BSFL_BIT_RESTART] = restart_reg;
        flags_now[`BSFL_BIT_QUEUE_EMPTY] = empty_reg;
        flags_now[`BSFL_BIT_QUEUE_OVER] = stream_mode ? stream_full_reg : over_flag;
        flags_now[`BSFL_BIT_CH2_UPPER_I:`BSFL_BIT_CH1_LOWER_T] = alarm_flags;
    end

    // Read data captured from the state before the clearing edge.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag_rdata <= 16'h0000;
        end else if (flag_rd) begin
            flag_rdata <= flags_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            queue_rdata <= 16'h0000;
        end else if (queue_rd) begin
            if (empty_reg) begin
                queue_rdata <= {`BSFL_EMPTY_TAG, flags_now[11:0]};
            end else begin
                queue_rdata <= queue_word;
            end
        end
    end

    // Streaming descriptor.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            desc_reg <= `BSFL_DESC_RESET;
        end else if (desc_wr) begin
            desc_reg <= desc_wdata;
        end
    end
    assign desc_rdata         = desc_reg;
    assign stream_word_count  = desc_reg[`BSFL_DESC_LEN_MSB:`BSFL_DESC_LEN_LSB];
    assign stream_start_addr  = desc_reg[`BSFL_DESC_ADDR_MSB:`BSFL_DESC_ADDR_LSB];
    assign stream_words_total = {1'b0, stream_word_count} + 9'h001;
endmodule : bsfl_flag_bank
`default_nettype wire

// file: logic/bsfl_regs.svh
/*
 * Register bit positions, reset values and widths for the bias status flag and
 * table stream descriptor bank.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BSFL_REGS_SVH
`define BSFL_REGS_SVH

`define BSFL_FLAG_WIDTH        16
`define BSFL_BIT_ALU_BUSY      11
`define BSFL_BIT_RESTART       10
`define BSFL_BIT_QUEUE_EMPTY   9
`define BSFL_BIT_QUEUE_OVER    8
`define BSFL_BIT_CH2_UPPER_I   7
`define BSFL_BIT_CH2_LOWER_I   6
`define BSFL_BIT_CH2_UPPER_T   5
`define BSFL_BIT_CH2_LOWER_T   4
`define BSFL_BIT_CH1_UPPER_I   3
`define BSFL_BIT_CH1_LOWER_I   2
`define BSFL_BIT_CH1_UPPER_T   1
`define BSFL_BIT_CH1_LOWER_T   0
`define BSFL_DESC_RESET        16'h0000
`define BSFL_DESC_LEN_MSB      15
`define BSFL_DESC_LEN_LSB      8
`define BSFL_DESC_ADDR_MSB     7
`define BSFL_DESC_ADDR_LSB     0
`define BSFL_SCLR_BIT_EXECUTE  6
`define BSFL_SCLR_BIT_ARM      5
`define BSFL_EMPTY_TAG         4'hf

`endif

// file: logic/bsfl_pkg.sv
/*
 * Types shared by the bias status flag bank.
 * Assumes the constants header is included where numbers are needed.
 */
package bsfl_pkg;
    typedef enum logic [1:0] {
        BSFL_MODE_MONITOR = 2'b00,
        BSFL_MODE_STREAM  = 2'b01
    } bsfl_mode_t;
    typedef enum logic [1:0] {
        BSFL_RST_IDLE  = 2'b00,
        BSFL_RST_ARMED = 2'b01
    } bsfl_rst_t;
endpackage : bsfl_pkg

// file: logic/bsfl_sticky_bit.sv
/*
 * One sticky flag: set by an event, cleared by a register read.
 * Assumes event and clear come from logic on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module bsfl_sticky_bit (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic reset,
    // Control.
    input  wire logic set_evt,
    input  wire logic clr_evt,
    // State.
    output logic      flag
);
    // Set wins over a clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_evt) begin
            flag <= 1'b0;
        end
    end
endmodule : bsfl_sticky_bit
`default_nettype wire

// file: verification/bsfl_flag_bank_asserts.sv
/* Port checks of bsfl_flag_bank.
   Assumes one core_clk domain with synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module bsfl_flag_bank_asserts (
    // Clock, reset and strobes.
    input wire logic core_clk, reset, flag_rd, desc_wr, sclr_wr, full_reset_pulse,
    // Status.
    input wire logic alu_busy, stream_mode, queue_count_zero, queue_push, queue_overflow,
    input wire logic [3:0] alarm_upper_i,
    // Data.
    input wire logic [15:0] desc_wdata, sclr_wdata, flag_rdata,
    input wire logic [7:0] stream_word_count, stream_start_addr,
    input wire logic [8:0] stream_words_total
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_arm; sclr_wr && sclr_wdata[6:5] == 2'h1; endsequence
    sequence s_exec; sclr_wr && sclr_wdata[6:5] == 2'h2; endsequence
    property p_busy; flag_rd |=> flag_rdata[11] == $past(alu_busy); endproperty
    a_busy: assert property (p_busy) else $error("busy bit");
    property p_fire; s_arm ##1 s_exec |=> full_reset_pulse; endproperty
    a_fire: assert property (p_fire) else $error("no reset pulse");
    property p_refuse; full_reset_pulse |-> $past(sclr_wr && sclr_wdata[6:5] == 2'h2); endproperty
    a_refuse: assert property (p_refuse) else $error("stray reset pulse");
    property p_restart; full_reset_pulse ##1 flag_rd |=> flag_rdata[10]; endproperty
    a_restart: assert property (p_restart) else $error("restart bit");
    property p_empty; queue_count_zero && !queue_push ##1 flag_rd |=> flag_rdata[9]; endproperty
    a_empty: assert property (p_empty) else $error("empty bit");
    property p_ovf; !stream_mode && queue_overflow ##1 flag_rd |=> flag_rdata[8]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow bit");
    property p_alarm; alarm_upper_i[2] ##1 flag_rd |=> flag_rdata[1]; endproperty
    a_alarm: assert property (p_alarm) else $error("alarm lost");
    property p_clear; flag_rd && !alarm_upper_i[0] ##1 flag_rd |=> !flag_rdata[3]; endproperty
    a_clear: assert property (p_clear) else $error("alarm not cleared");
    property p_desc; desc_wr |=> {stream_word_count, stream_start_addr} == $past(desc_wdata);
    endproperty
    a_desc: assert property (p_desc) else $error("descriptor");
    property p_total; stream_words_total == {1'h0, stream_word_count} + 9'h1; endproperty
    a_total: assert property (p_total) else $error("word total");
endmodule : bsfl_flag_bank_asserts
bind bsfl_flag_bank bsfl_flag_bank_asserts bsfl_flag_bank_asserts_i (.*);
`default_nettype wire

// file: verification/bsfl_host_model.sv
/* Host side of the register port: one set of strobes per cycle.
   Assumes the bench supplies core_clk. */
`timescale 1ns/1ns
`default_nettype none
module bsfl_host_model (
    // Clock.
    input wire logic core_clk,
    // Strobes and write data.
    output var logic flag_rd, queue_rd, desc_wr, sclr_wr,
    output var logic [15:0] desc_wdata, sclr_wdata
);
    initial {flag_rd, queue_rd, desc_wr, sclr_wr, desc_wdata, sclr_wdata} = '0;
    // Idle write buses show the inverse of their last value.
    task strobe(input logic [3:0] s, input logic [15:0] d);
        @(negedge core_clk);
        {flag_rd, queue_rd, desc_wr, sclr_wr} <= s;
        desc_wdata <= s[1] ? d : ~desc_wdata;
        sclr_wdata <= s[0] ? d : ~sclr_wdata;
    endtask : strobe
endmodule : bsfl_host_model
`default_nettype wire

// file: verification/bsfl_flag_bank_tb.sv
/* Bench for bsfl_flag_bank with a reference model and random alarms.
   Assumes the host model and bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module bsfl_flag_bank_tb;
    logic core_clk = 1'h0, reset = 1'h1, alu_busy = 1'h0, ch2_use_die_sensor = 1'h0;
    logic stream_mode = 1'h0, queue_full = 1'h0, queue_pop = 1'h0, queue_count_zero = 1'h1;
    logic queue_push = 1'h0, queue_overflow = 1'h0, die_upper_alarm = 1'h0;
    logic die_lower_alarm = 1'h0, armed, mp, rd_seen, q_seen;
    logic [3:0] alarm_upper_i = 4'h0, alarm_lower_i = 4'h0;
    logic [15:0] queue_word = 16'h0, mf, md, exp_f, exp_q;
    wire logic flag_rd, queue_rd, desc_wr, sclr_wr, full_reset_pulse;
    wire logic [15:0] desc_wdata, sclr_wdata, flag_rdata, desc_rdata, queue_rdata;
    wire logic [7:0] stream_word_count, stream_start_addr;
    wire logic [8:0] stream_words_total;
    wire logic [15:0] m = ch2_use_die_sensor ? 16'h0fcf : 16'h0fff;
    int mismatches = 0, checked = 0;
    bsfl_host_model bsfl_host_model_i (.*);
    bsfl_flag_bank bsfl_flag_bank_i (.*);
    always #5 core_clk = ~core_clk;
    // Reference model of flags, descriptor and reset arming.
    always @(posedge core_clk) begin
        rd_seen = flag_rd;
        q_seen = queue_rd && mf[9] === queue_count_zero;
        exp_f = {4'h0, alu_busy, mf[10:0]};
        exp_q = mf[9] ? {4'hf, exp_f[11:0]} : queue_word;
        if (reset) begin
            {mf, md, armed, mp} = {16'h0200, 16'h0, 2'h0};
        end else begin
            if (flag_rd) mf = mf & 16'hfa00;
            mf = mf | {5'h0, mp, 1'h0, queue_overflow,
                       ch2_use_die_sensor ? die_upper_alarm : alarm_upper_i[1],
                       ch2_use_die_sensor ? die_lower_alarm : alarm_lower_i[1],
                       alarm_upper_i[3], alarm_lower_i[3], alarm_upper_i[0],
                       alarm_lower_i[0], alarm_upper_i[2], alarm_lower_i[2]};
            mf[9] = queue_count_zero & !queue_push;
            if (desc_wr) md = desc_wdata;
            mp = sclr_wr & armed & sclr_wdata[6] & !sclr_wdata[5];
            if (sclr_wr) armed = sclr_wdata[5] & !sclr_wdata[6];
        end
    end
    task check(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // One cycle: strobes from the host, compare, then new status inputs.
    task step(input logic [3:0] s, input logic [15:0] d, input logic r);
        bsfl_host_model_i.strobe(s, d);
        check("pulse", {15'h0, full_reset_pulse}, {15'h0, mp});
        if (rd_seen) check("flags", flag_rdata & m, exp_f & m);
        if (q_seen) check("queue", queue_rdata & (m | 16'hf000), exp_q & (m | 16'hf000));
        check("desc", desc_rdata, md);
        check("fields", {stream_word_count, stream_start_addr}, md);
        check("total", {7'h0, stream_words_total}, {8'h0, md[15:8]} + 16'h1);
        if (r) begin
            alarm_upper_i <= 4'($urandom & $urandom & $urandom);
            alarm_lower_i <= 4'($urandom & $urandom & $urandom);
            {die_upper_alarm, die_lower_alarm, alu_busy, queue_count_zero} <= 4'($urandom);
            {queue_overflow, queue_push} <= {$urandom % 8 == 0, $urandom % 4 == 0};
            queue_word <= 16'($urandom);
        end else begin
            {alarm_upper_i, alarm_lower_i, die_upper_alarm, die_lower_alarm} <= 10'h0;
            {queue_overflow, queue_push} <= 2'h0;
        end
    endtask : step
    initial begin
        logic [15:0] dv [4];
        dv = '{16'hff00, 16'h00ff, 16'h5aa5, 16'h0000};
        void'($urandom(93));
        repeat (5) @(negedge core_clk);
        reset <= 1'h0;
        foreach (dv[i]) step(4'h2, dv[i], 1'h0);
        $display("test descriptor done");
        step(4'h1, 16'h0040, 1'h0);
        step(4'h1, 16'h0060, 1'h0);
        step(4'h1, 16'h0020, 1'h0);
        step(4'h1, 16'h0040, 1'h0);
        repeat (3) step(4'h8, 16'h0, 1'h0);
        $display("test full reset done");
        repeat (400) step({$urandom % 3 == 0, $urandom % 4 == 0, 2'h0}, 16'h0, 1'h1);
        repeat (3) step(4'h8, 16'h0, 1'h0);
        ch2_use_die_sensor <= 1'h1;
        repeat (400) step({$urandom % 3 == 0, $urandom % 4 == 0, 2'h0}, 16'h0, 1'h1);
        step(4'h0, 16'h0, 1'h0);
        $display("test random alarms done");
        give_verdict;
    end
    initial begin
        #100000;
        mismatches++;
        give_verdict;
    end
endmodule : bsfl_flag_bank_tb
`default_nettype wire
